// >>> inc/vme_slave_pkg.sv
// Shared constants, field layouts and carrier types for the slave images.
// Assumes a 12-bit register offset port and 32-bit VMEbus addresses.
package vme_slave_pkg;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int ADDR_W = 32;
  localparam int REG_AW = 12;
  localparam int AM_W   = 6;

  // ==========================================================================
  // Register offsets (byte addresses)
  // ==========================================================================
  localparam logic [REG_AW-1:0] OFF_IMG1_BOUND = 12'hF1C;
  localparam logic [REG_AW-1:0] OFF_IMG1_XLAT  = 12'hF20;
  localparam logic [REG_AW-1:0] OFF_IMG2_CTL   = 12'hF28;
  localparam logic [REG_AW-1:0] OFF_IMG2_BASE  = 12'hF2C;
  localparam logic [REG_AW-1:0] OFF_IMG2_BOUND = 12'hF30;
  localparam logic [REG_AW-1:0] OFF_IMG2_XLAT  = 12'hF34;
  localparam logic [REG_AW-1:0] OFF_IMG3_CTL   = 12'hF3C;
  localparam logic [REG_AW-1:0] OFF_IMG3_BASE  = 12'hF40;
  localparam logic [REG_AW-1:0] OFF_IMG3_BOUND = 12'hF44;
  localparam logic [REG_AW-1:0] OFF_IMG3_XLAT  = 12'hF48;

  // ==========================================================================
  // Control word layout, writable masks and reset values
  // ==========================================================================
  localparam int CTL_EN_BIT    = 31;
  localparam int CTL_POST_BIT  = 30;
  localparam int CTL_PREF_BIT  = 29;
  localparam int CTL_PGM_LSB   = 22;
  localparam int CTL_PRIV_LSB  = 20;
  localparam int CTL_VAS_LSB   = 16;
  localparam int CTL_WIDE_BIT  = 7;
  localparam int CTL_LOCK_BIT  = 6;
  localparam int CTL_SPACE_LSB = 0;
  localparam logic [31:0] CTL_WMASK = 32'hE0F7_00C3;
  localparam logic [31:0] CTL_RESET = 32'h00F0_0000;
  localparam logic [31:0] WIN_MASK  = 32'hFFFF_0000;
  localparam logic [31:0] WIN_RESET = 32'h0000_0000;
  localparam int WIN_LSB = 16;
  localparam int A24_TOP = 23;

  // ==========================================================================
  // Field encodings
  // ==========================================================================
  localparam logic [2:0] VAS_A24   = 3'h1;
  localparam logic [2:0] VAS_A32   = 3'h2;
  localparam logic [2:0] VAS_USER1 = 3'h6;
  localparam logic [2:0] VAS_USER2 = 3'h7;
  localparam logic [1:0] SPACE_MEM = 2'h0;
  localparam logic [1:0] SPACE_IO  = 2'h1;
  localparam logic [1:0] SPACE_CFG = 2'h2;
  localparam logic [1:0] SPACE_RSV = 2'h3;

  // Address modifier classes: upper bits select space, low bits the kind.
  localparam logic [2:0] AM_A24_HI   = 3'h7;
  localparam logic [2:0] AM_A32_HI   = 3'h1;
  localparam logic [1:0] AM_USER1_HI = 2'h1;
  localparam logic [1:0] AM_USER2_HI = 2'h2;
  localparam logic [1:0] AM_PGM_LO   = 2'h2;
  localparam int         AM_SUP_BIT  = 2;

  // ==========================================================================
  // Carrier types
  // ==========================================================================
  typedef struct packed {
    logic       en;
    logic       post_en;
    logic       pref_en;
    logic [1:0] program_data_filter;
    logic [1:0] priv;
    logic [2:0] vme_space_select;
    logic       wide;
    logic       lock;
    logic [1:0] space;
  } img_ctl_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [AM_W-1:0]   am;
    logic              write;
    logic              rmw;
  } vme_cycle_t;

  typedef struct packed {
    logic       known;
    logic [2:0] space;
    logic       prog;
    logic       sup;
  } am_class_t;

  typedef struct packed {
    logic [ADDR_W-1:0] pci_addr;
    logic [1:0]        space;
    logic              post;
    logic              pref;
    logic              wide;
    logic              lock;
  } route_t;

  // Splits a control word into its fields.
  function automatic img_ctl_t unpack_ctl(input logic [31:0] w);
    img_ctl_t c;
    c.en      = w[CTL_EN_BIT];
    c.post_en = w[CTL_POST_BIT];
    c.pref_en = w[CTL_PREF_BIT];
    c.program_data_filter     = w[CTL_PGM_LSB +: 2];
    c.priv    = w[CTL_PRIV_LSB +: 2];
    c.vme_space_select     = w[CTL_VAS_LSB +: 3];
    c.wide    = w[CTL_WIDE_BIT];
    c.lock    = w[CTL_LOCK_BIT];
    c.space   = w[CTL_SPACE_LSB +: 2];
    return c;
  endfunction : unpack_ctl

endpackage : vme_slave_pkg

// >>> src/am_classify.sv
// Classifies an incoming VMEbus address modifier code.
// Assumes the code is stable while the decode samples it.
`timescale 1ns/100ps
module am_classify (
  // Incoming code
  input  wire logic [vme_slave_pkg::AM_W-1:0] am,
  // Classification
  output vme_slave_pkg::am_class_t             cls
);

  // ==========================================================================
  // Space detection
  // ==========================================================================
  // Each space is recognised from the upper code bits.
  wire logic is_a24 = (am[5:3] == vme_slave_pkg::AM_A24_HI);
  wire logic is_a32 = (am[5:3] == vme_slave_pkg::AM_A32_HI);
  wire logic is_u1  = (am[5:4] == vme_slave_pkg::AM_USER1_HI);
  wire logic is_u2  = (am[5:4] == vme_slave_pkg::AM_USER2_HI);

  // Space code, program and privilege flags of the cycle.
  assign cls.known = is_a24 | is_a32 | is_u1 | is_u2;
  assign cls.space = is_a24 ? vme_slave_pkg::VAS_A24 :
                     is_a32 ? vme_slave_pkg::VAS_A32 :
                     is_u1  ? vme_slave_pkg::VAS_USER1 :
                              vme_slave_pkg::VAS_USER2;
  assign cls.prog  = (am[1:0] == vme_slave_pkg::AM_PGM_LO);
  assign cls.sup   = am[vme_slave_pkg::AM_SUP_BIT];

endmodule : am_classify

// >>> src/image_window.sv
// One slave image: window compare, modifier filters and PCI routing.
// Assumes the control word and window registers are held by the caller.
`timescale 1ns/100ps
module image_window (
  // Image settings
  input  wire logic [31:0]                ctl_word,
  input  wire logic [31:0]                base,
  input  wire logic [31:0]                bound,
  input  wire logic [31:0]                xlat,
  input  wire logic                       bm_en,
  // Incoming cycle
  input  vme_slave_pkg::vme_cycle_t       cyc,
  input  vme_slave_pkg::am_class_t        cls,
  // Decision
  output logic                            hit,
  output vme_slave_pkg::route_t           route
);

  vme_slave_pkg::img_ctl_t c;
  logic [31:0] addr_eff;
  logic [15:0] a_hi;
  logic        in_win;
  logic        pgm_ok;
  logic        priv_ok;
  logic        vas_ok;
  logic        mem;

  assign c = vme_slave_pkg::unpack_ctl(ctl_word);

  // A24 cycles carry only 24 significant address bits.
  assign addr_eff = (cls.space == vme_slave_pkg::VAS_A24) ?
                    {8'h00, cyc.addr[vme_slave_pkg::A24_TOP:0]} : cyc.addr;

  // Window compare on the upper sixteen bits only.
  assign a_hi   = addr_eff[31:vme_slave_pkg::WIN_LSB];
  assign in_win = (a_hi >= base[31:vme_slave_pkg::WIN_LSB]) &&
                  (a_hi <  bound[31:vme_slave_pkg::WIN_LSB]);

  // Filters: bit 0 admits data/user codes, bit 1 program/supervisor codes.
  assign pgm_ok  = cls.prog ? c.program_data_filter[1]  : c.program_data_filter[0];
  assign priv_ok = cls.sup  ? c.priv[1] : c.priv[0];
  assign vas_ok  = cls.known && (cls.space == c.vme_space_select);

  // Claim needs enable, bus master enable and a defined PCI space.
  assign hit = c.en && bm_en && in_win && pgm_ok && priv_ok && vas_ok &&
               (c.space != vme_slave_pkg::SPACE_RSV);

  // Routing; posting and prefetch only apply to memory space.
  assign mem            = (c.space == vme_slave_pkg::SPACE_MEM);
  assign route.pci_addr = {a_hi + xlat[31:vme_slave_pkg::WIN_LSB],
                           addr_eff[vme_slave_pkg::WIN_LSB-1:0]};
  assign route.space    = c.space;
  assign route.post     = mem && c.post_en && cyc.write;
  assign route.pref     = mem && c.pref_en && !cyc.write;
  assign route.wide     = c.wide;
  assign route.lock     = c.lock && cyc.rmw;

endmodule : image_window

// >>> src/vme_slave_image_decode.sv
// Register file and decode of VMEbus slave images 1 to 3.
// Image 1 control and base arrive as ports from the rest of the chip; the
// PCI bus master enable comes from the PCI command/status register.
// Functional notes
// - Claim only addresses at or above base and strictly below bound.
// - Posted-write and prefetch enables: 0 off, 1 on, both reset 0.
// - Only memory-space transactions are posted; posted writes go to memory.
// - Non-memory PCI space forces posting and prefetch off.
// - Respond only when image enabled and PCI bus master enabled.
// - Program/data filter: 01 data, 10 program, 11 both, resets 11.
// - Privilege filter: 01 user, 10 supervisor, 11 both, resets 11.
// - Space select: 001 A24, 010 A32, 110 user1, 111 user2, resets 0.
// - Wide transfer enable allows 64-bit PCI use; resets 0.
// - Lock enable locks PCI during decoded read-modify-write; resets 0.
// - PCI space: 00 memory, 01 I/O, 10 config, 11 reserved; resets 0.
`timescale 1ns/100ps
module vme_slave_image_decode (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // Register access port
  input  wire logic [11:0] REG_ADDR,
  input  wire logic        REG_WRITE,
  input  wire logic        REG_READ,
  input  wire logic [31:0] REG_WDATA,
  output logic      [31:0] REG_RDATA,
  output logic             REG_RVALID,
  // Settings held elsewhere in the chip
  input  wire logic [31:0] IMG1_CTL,
  input  wire logic [31:0] IMG1_BASE,
  input  wire logic        PCI_BUS_MASTER_EN,
  // Incoming VMEbus cycle
  input  wire logic        VME_VALID,
  input  wire logic [31:0] VME_ADDR,
  input  wire logic [5:0]  VME_AM,
  input  wire logic        VME_WRITE,
  input  wire logic        VME_RMW,
  // Decode result towards PCI
  output logic             DEC_DONE,
  output logic             DEC_HIT,
  output logic      [1:0]  DEC_IMAGE,
  output logic      [31:0] PCI_ADDR,
  output logic      [1:0]  PCI_SPACE,
  output logic             POST_WRITE,
  output logic             PREFETCH,
  output logic             WIDE_XFER,
  output logic             PCI_LOCK
);

  localparam int NIMG = 3;

  // ==========================================================================
  // Register storage
  // ==========================================================================
  logic [31:0] ctl2_r;
  logic [31:0] ctl3_r;
  logic [31:0] base2_r;
  logic [31:0] base3_r;
  logic [31:0] bound1_r;
  logic [31:0] bound2_r;
  logic [31:0] bound3_r;
  logic [31:0] xlat1_r;
  logic [31:0] xlat2_r;
  logic [31:0] xlat3_r;

  // ==========================================================================
  // Register address decode
  // ==========================================================================
  // One strobe per register, qualified by the write request.
  wire logic wr_bound1 = REG_WRITE &&
                         (REG_ADDR == vme_slave_pkg::OFF_IMG1_BOUND);
  wire logic wr_xlat1  = REG_WRITE &&
                         (REG_ADDR == vme_slave_pkg::OFF_IMG1_XLAT);
  wire logic wr_ctl2   = REG_WRITE &&
                         (REG_ADDR == vme_slave_pkg::OFF_IMG2_CTL);
  wire logic wr_base2  = REG_WRITE &&
                         (REG_ADDR == vme_slave_pkg::OFF_IMG2_BASE);
  wire logic wr_bound2 = REG_WRITE &&
                         (REG_ADDR == vme_slave_pkg::OFF_IMG2_BOUND);
  wire logic wr_xlat2  = REG_WRITE &&
                         (REG_ADDR == vme_slave_pkg::OFF_IMG2_XLAT);
  wire logic wr_ctl3   = REG_WRITE &&
                         (REG_ADDR == vme_slave_pkg::OFF_IMG3_CTL);
  wire logic wr_base3  = REG_WRITE &&
                         (REG_ADDR == vme_slave_pkg::OFF_IMG3_BASE);
  wire logic wr_bound3 = REG_WRITE &&
                         (REG_ADDR == vme_slave_pkg::OFF_IMG3_BOUND);
  wire logic wr_xlat3  = REG_WRITE &&
                         (REG_ADDR == vme_slave_pkg::OFF_IMG3_XLAT);

  // Write data with reserved bits forced to zero.
  wire logic [31:0] wd_ctl = REG_WDATA & vme_slave_pkg::CTL_WMASK;
  wire logic [31:0] wd_win = REG_WDATA & vme_slave_pkg::WIN_MASK;

  // ==========================================================================
  // Control registers
  // ==========================================================================
  // Control words reset with both filters open and all enables off.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctl2_r <= vme_slave_pkg::CTL_RESET;
      ctl3_r <= vme_slave_pkg::CTL_RESET;
    end else begin
      if (wr_ctl2) begin
        ctl2_r <= wd_ctl;
      end
      if (wr_ctl3) begin
        ctl3_r <= wd_ctl;
      end
    end
  end

  // ==========================================================================
  // Window registers
  // ==========================================================================
  // Base registers.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      base2_r <= vme_slave_pkg::WIN_RESET;
      base3_r <= vme_slave_pkg::WIN_RESET;
    end else begin
      if (wr_base2) begin
        base2_r <= wd_win;
      end
      if (wr_base3) begin
        base3_r <= wd_win;
      end
    end
  end

  // Bound registers.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      bound1_r <= vme_slave_pkg::WIN_RESET;
      bound2_r <= vme_slave_pkg::WIN_RESET;
      bound3_r <= vme_slave_pkg::WIN_RESET;
    end else begin
      if (wr_bound1) begin
        bound1_r <= wd_win;
      end
      if (wr_bound2) begin
        bound2_r <= wd_win;
      end
      if (wr_bound3) begin
        bound3_r <= wd_win;
      end
    end
  end

  // Translation offset registers.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      xlat1_r <= vme_slave_pkg::WIN_RESET;
      xlat2_r <= vme_slave_pkg::WIN_RESET;
      xlat3_r <= vme_slave_pkg::WIN_RESET;
    end else begin
      if (wr_xlat1) begin
        xlat1_r <= wd_win;
      end
      if (wr_xlat2) begin
        xlat2_r <= wd_win;
      end
      if (wr_xlat3) begin
        xlat3_r <= wd_win;
      end
    end
  end

  // ==========================================================================
  // Register read path
  // ==========================================================================
  // Unmapped offsets read as zero.
  wire logic [31:0] rd_mux =
    (REG_ADDR == vme_slave_pkg::OFF_IMG1_BOUND) ? bound1_r :
    (REG_ADDR == vme_slave_pkg::OFF_IMG1_XLAT)  ? xlat1_r  :
    (REG_ADDR == vme_slave_pkg::OFF_IMG2_CTL)   ? ctl2_r   :
    (REG_ADDR == vme_slave_pkg::OFF_IMG2_BASE)  ? base2_r  :
    (REG_ADDR == vme_slave_pkg::OFF_IMG2_BOUND) ? bound2_r :
    (REG_ADDR == vme_slave_pkg::OFF_IMG2_XLAT)  ? xlat2_r  :
    (REG_ADDR == vme_slave_pkg::OFF_IMG3_CTL)   ? ctl3_r   :
    (REG_ADDR == vme_slave_pkg::OFF_IMG3_BASE)  ? base3_r  :
    (REG_ADDR == vme_slave_pkg::OFF_IMG3_BOUND) ? bound3_r :
    (REG_ADDR == vme_slave_pkg::OFF_IMG3_XLAT)  ? xlat3_r  :
    32'h0000_0000;

  // Read data is captured on the edge that samples the read strobe.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      REG_RDATA  <= 32'h0000_0000;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_READ;
      if (REG_READ) begin
        REG_RDATA <= rd_mux;
      end
    end
  end

  // ==========================================================================
  // Incoming cycle classification
  // ==========================================================================
  vme_slave_pkg::vme_cycle_t cyc;
  vme_slave_pkg::am_class_t  cls;

  assign cyc.addr  = VME_ADDR;
  assign cyc.am    = VME_AM;
  assign cyc.write = VME_WRITE;
  assign cyc.rmw   = VME_RMW;

  // One classifier serves all three images.
  am_classify u_am (
    .am  (VME_AM),
    .cls (cls)
  );

  // ==========================================================================
  // Image windows
  // ==========================================================================
  logic [NIMG-1:0]       hit;
  vme_slave_pkg::route_t route [NIMG];

  // Image 1 takes control and base from outside the block.
  image_window u_img1 (
    .ctl_word (IMG1_CTL),
    .base     (IMG1_BASE & vme_slave_pkg::WIN_MASK),
    .bound    (bound1_r),
    .xlat     (xlat1_r),
    .bm_en    (PCI_BUS_MASTER_EN),
    .cyc      (cyc),
    .cls      (cls),
    .hit      (hit[0]),
    .route    (route[0])
  );

  // Image 2.
  image_window u_img2 (
    .ctl_word (ctl2_r),
    .base     (base2_r),
    .bound    (bound2_r),
    .xlat     (xlat2_r),
    .bm_en    (PCI_BUS_MASTER_EN),
    .cyc      (cyc),
    .cls      (cls),
    .hit      (hit[1]),
    .route    (route[1])
  );

  // Image 3.
  image_window u_img3 (
    .ctl_word (ctl3_r),
    .base     (base3_r),
    .bound    (bound3_r),
    .xlat     (xlat3_r),
    .bm_en    (PCI_BUS_MASTER_EN),
    .cyc      (cyc),
    .cls      (cls),
    .hit      (hit[2]),
    .route    (route[2])
  );

  // ==========================================================================
  // Image selection
  // ==========================================================================
  // Overlapping windows resolve to the lowest numbered image.
  wire logic [1:0] sel_img = hit[0] ? 2'h1 :
                             hit[1] ? 2'h2 :
                             hit[2] ? 2'h3 : 2'h0;
  wire vme_slave_pkg::route_t sel_route = hit[0] ? route[0] :
                                          hit[1] ? route[1] : route[2];
  wire logic any_hit = |hit;

  // ==========================================================================
  // Registered decode result
  // ==========================================================================
  // Done pulses one cycle after each valid cycle; routing holds until next.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      DEC_DONE <= 1'b0;
      DEC_HIT  <= 1'b0;
    end else begin
      DEC_DONE <= VME_VALID;
      if (VME_VALID) begin
        DEC_HIT <= any_hit;
      end
    end
  end

  // Routing fields are cleared on a miss so nothing stale is forwarded.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      DEC_IMAGE  <= 2'h0;
      PCI_ADDR   <= 32'h0000_0000;
      PCI_SPACE  <= vme_slave_pkg::SPACE_MEM;
      POST_WRITE <= 1'b0;
      PREFETCH   <= 1'b0;
      WIDE_XFER  <= 1'b0;
      PCI_LOCK   <= 1'b0;
    end else if (VME_VALID) begin
      DEC_IMAGE  <= sel_img;
      PCI_ADDR   <= any_hit ? sel_route.pci_addr : 32'h0000_0000;
      PCI_SPACE  <= any_hit ? sel_route.space : vme_slave_pkg::SPACE_MEM;
      POST_WRITE <= any_hit && sel_route.post;
      PREFETCH   <= any_hit && sel_route.pref;
      WIDE_XFER  <= any_hit && sel_route.wide;
      PCI_LOCK   <= any_hit && sel_route.lock;
    end
  end

endmodule : vme_slave_image_decode

// >>> verif/tb.sv
// Self-checking bench for the slave image decode block.
// Assumes the master model offers cycles; the bench owns registers.
`timescale 1ns/100ps
module tb;
  // ==========================================================================
  // Signals
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic [11:0] ra = 12'h000;
  logic        rw = 1'h0;
  logic        rr = 1'h0;
  logic [31:0] wd = 32'h0000_0000;
  logic        bm = 1'h1;
  logic [31:0] i1c = 32'h0000_0000, i1b = 32'h0000_0000;
  logic [31:0] rdata, paddr;
  logic        rvalid, done, hit, pw, pf, wx, lk, vld;
  logic [1:0]  img, psp;
  vme_slave_pkg::vme_cycle_t cyc;
  logic [5:0]  am_of [4] = '{6'h39, 6'h09, 6'h10, 6'h20};
  logic [2:0]  vas_of [4] = '{3'h1, 3'h2, 3'h6, 3'h7};
  int          n_fail = 0;
  int          cmp_count = 0;
  // Clock of 20 ns.
  always #10 clk = ~clk;
  // Master model and the block.
  vme_master_model m (.clk(clk), .valid(vld), .cyc(cyc));
  vme_slave_image_decode DUT (
    .CLK(clk), .RST(rst), .REG_ADDR(ra), .REG_WRITE(rw), .REG_READ(rr),
    .REG_WDATA(wd), .REG_RDATA(rdata), .REG_RVALID(rvalid),
    .IMG1_CTL(i1c), .IMG1_BASE(i1b),
    .PCI_BUS_MASTER_EN(bm), .VME_VALID(vld), .VME_ADDR(cyc.addr),
    .VME_AM(cyc.am), .VME_WRITE(cyc.write), .VME_RMW(cyc.rmw),
    .DEC_DONE(done), .DEC_HIT(hit), .DEC_IMAGE(img), .PCI_ADDR(paddr),
    .PCI_SPACE(psp), .POST_WRITE(pw), .PREFETCH(pf), .WIDE_XFER(wx),
    .PCI_LOCK(lk));
  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    ra <= a;
    wd <= d;
    rw <= 1'h1;
    @(posedge clk);
    rw <= 1'h0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    ra <= a;
    rr <= 1'h1;
    @(posedge clk);
    rr <= 1'h0;
    #1;
    chk({31'h0000_0000, rvalid}, 32'h0000_0001, "rvalid");
    chk(rdata, e, "rdata");
  endtask : rd
  task automatic dec(input logic [31:0] a, input logic [5:0] am,
                     input logic w, x, input logic [1:0] ei,
                     input logic [31:0] ea);
    m.drive('{addr: a, am: am, write: w, rmw: x});
    #1;
    chk({31'h0000_0000, done}, 32'h0000_0001, "done");
    chk({29'h0000_0000, hit, img}, {29'h0000_0000, ei != 2'h0, ei}, "hit");
    chk(paddr, ea, "pci address");
  endtask : dec
  task automatic flg(input logic [5:0] e);
    chk({26'h000_0000, psp, pw, pf, wx, lk}, {26'h000_0000, e}, "flags");
  endtask : flg
  // ==========================================================================
  // Scenarios
  task automatic t_regs;
    rd(12'hF28, 32'h00F0_0000);
    rd(12'hF3C, 32'h00F0_0000);
    rd(12'hF30, 32'h0000_0000);
    rd(12'hF00, 32'h0000_0000);
    wr(12'hF3C, 32'hFFFF_FFFF);
    rd(12'hF3C, 32'hE0F7_00C3);
    wr(12'hF40, 32'h0FFF_FFFF);
    rd(12'hF40, 32'h0FFF_0000);
    $display("test regs done");
  endtask : t_regs
  task automatic t_window;
    wr(12'hF2C, 32'h1000_0000);
    wr(12'hF30, 32'h1002_FFFF);
    wr(12'hF34, 32'hF001_FFFF);
    wr(12'hF28, 32'h80F2_0000);
    dec(32'h1000_0000, 6'h09, 0, 0, 2'h2, 32'h0001_0000);
    dec(32'h1001_ABCD, 6'h09, 0, 0, 2'h2, 32'h0002_ABCD);
    dec(32'h1002_0000, 6'h09, 0, 0, 2'h0, 32'h0000_0000);
    dec(32'h0FFF_FFFF, 6'h09, 0, 0, 2'h0, 32'h0000_0000);
    @(posedge clk);
    bm <= 1'h0;
    dec(32'h1000_0000, 6'h09, 0, 0, 2'h0, 32'h0000_0000);
    @(posedge clk);
    bm <= 1'h1;
    wr(12'hF28, 32'h00F2_0000);
    dec(32'h1000_0000, 6'h09, 0, 0, 2'h0, 32'h0000_0000);
    $display("test window done");
  endtask : t_window
  task automatic t_route;
    for (int s = 0; s < 4; s++) begin
      wr(12'hF28, 32'hE0F2_00C0 | 32'(s));
      dec(32'h1000_0000, 6'h09, 1, 1, s == 3 ? 2'h0 : 2'h2,
          s == 3 ? 32'h0000_0000 : 32'h0001_0000);
      flg(s == 3 ? 6'h00 : {2'(s), s == 0, 1'h0, 2'h3});
      dec(32'h1000_0000, 6'h09, 0, 0, s == 3 ? 2'h0 : 2'h2,
          s == 3 ? 32'h0000_0000 : 32'h0001_0000);
      flg(s == 3 ? 6'h00 : {2'(s), 1'h0, s == 0, 2'h2});
    end
    wr(12'hF28, 32'h80F2_0000);
    dec(32'h1000_0000, 6'h09, 1, 1, 2'h2, 32'h0001_0000);
    flg(6'h00);
    $display("test route done");
  endtask : t_route
  task automatic t_filters;
    logic [5:0] a;
    logic       h;
    for (int p = 0; p < 16; p++) begin
      wr(12'hF28, 32'h8002_0000 | (32'(p) << 20));
      for (int k = 0; k < 4; k++) begin
        a = (k[0] ? 6'h0A : 6'h09) | (k[1] ? 6'h04 : 6'h00);
        h = p[2 + (a[1:0] == 2'h2)] & p[a[2]];
        dec(32'h1000_0000, a, 0, 0, h ? 2'h2 : 2'h0,
            h ? 32'h0001_0000 : 32'h0000_0000);
      end
    end
    $display("test filters done");
  endtask : t_filters
  task automatic t_space;
    logic h;
    wr(12'hF2C, 32'h0000_0000);
    for (int v = 0; v < 8; v++) begin
      wr(12'hF28, 32'h80F0_0000 | (32'(v) << 16));
      for (int k = 0; k < 4; k++) begin
        h = vas_of[k] == 3'(v);
        dec(32'h0000_1234, am_of[k], 0, 0, h ? 2'h2 : 2'h0,
            h ? 32'hF001_1234 : 32'h0000_0000);
      end
    end
    $display("test space done");
  endtask : t_space
  task automatic t_images;
    wr(12'hF44, 32'h1002_FFFF);
    wr(12'hF48, 32'h0001_FFFF);
    wr(12'hF3C, 32'h80F2_0000);
    wr(12'hF1C, 32'h1001_FFFF);
    wr(12'hF20, 32'h0003_0000);
    i1b <= 32'h1000_FFFF;
    i1c <= 32'h80F2_0000;
    dec(32'h1000_0000, 6'h09, 0, 0, 2'h1, 32'h1003_0000);
    dec(32'h1001_0000, 6'h09, 0, 0, 2'h3, 32'h1002_0000);
    $display("test images done");
  endtask : t_images
  // ==========================================================================
  // Verdict
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude
  // Main sequence after two reset cycles.
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    t_regs();
    t_window();
    t_route();
    t_filters();
    t_space();
    t_images();
    conclude();
  end
  // Watchdog well beyond the expected run length.
  initial begin
    #400000;
    n_fail++;
    conclude();
  end
endmodule : tb
// Checker beside the top module.
bind vme_slave_image_decode vsid_properties chk_i (
  .CLK(CLK), .RST(RST), .PCI_BUS_MASTER_EN(PCI_BUS_MASTER_EN),
  .VME_VALID(VME_VALID), .VME_ADDR(VME_ADDR), .VME_WRITE(VME_WRITE),
  .VME_RMW(VME_RMW), .DEC_DONE(DEC_DONE), .DEC_HIT(DEC_HIT),
  .DEC_IMAGE(DEC_IMAGE), .PCI_ADDR(PCI_ADDR), .PCI_SPACE(PCI_SPACE),
  .POST_WRITE(POST_WRITE), .PREFETCH(PREFETCH), .PCI_LOCK(PCI_LOCK));

// >>> verif/vme_master_model.sv
// Behavioural VMEbus master offering one cycle at a time.
// Assumes the caller judges the decode answer after each cycle.
`timescale 1ns/100ps
module vme_master_model (
  // Clock
  input wire logic           clk,
  // Cycle towards the block
  output logic               valid,
  output vme_slave_pkg::vme_cycle_t cyc
);
  // Lines start idle.
  initial begin
    valid = 1'h0;
    cyc = '0;
  end
  // Holds a cycle for the edge that takes it; idle lines then invert.
  task automatic drive(input vme_slave_pkg::vme_cycle_t c);
    @(posedge clk);
    valid <= 1'h1;
    cyc <= c;
    @(posedge clk);
    valid <= 1'h0;
    cyc <= ~c;
  endtask : drive
endmodule : vme_master_model

// >>> verif/vsid_properties.sv
// Concurrent checks on the decode outputs of the slave images.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
module vsid_properties (
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RST,
  // Inputs watched
  input wire logic        PCI_BUS_MASTER_EN,
  input wire logic        VME_VALID,
  input wire logic [31:0] VME_ADDR,
  input wire logic        VME_WRITE,
  input wire logic        VME_RMW,
  // Outputs watched
  input wire logic        DEC_DONE,
  input wire logic        DEC_HIT,
  input wire logic [1:0]  DEC_IMAGE,
  input wire logic [31:0] PCI_ADDR,
  input wire logic [1:0]  PCI_SPACE,
  input wire logic        POST_WRITE,
  input wire logic        PREFETCH,
  input wire logic        PCI_LOCK
);
  // ==========================================================================
  // Properties
  // All checks share the block clock and its reset.
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  chk_done_next: assert property (VME_VALID |=> DEC_DONE)
    else $error("decode not answered one edge later");
  chk_low_addr: assert property (VME_VALID ##1 DEC_HIT |->
    PCI_ADDR[15:0] == $past(VME_ADDR[15:0]))
    else $error("low address bits not passed through");
  chk_no_master: assert property (VME_VALID && !PCI_BUS_MASTER_EN
    |=> !DEC_HIT) else $error("claim without bus master enable");
  chk_miss_quiet: assert property (DEC_DONE && !DEC_HIT |->
    DEC_IMAGE == 2'h0 && PCI_ADDR == 32'h0000_0000)
    else $error("miss left image or address set");
  chk_post_mem: assert property (POST_WRITE || PREFETCH |->
    PCI_SPACE == vme_slave_pkg::SPACE_MEM)
    else $error("posting outside memory space");
  chk_post_dir: assert property (VME_VALID && !VME_WRITE
    |=> !POST_WRITE) else $error("read cycle was posted");
  chk_lock_rmw: assert property (VME_VALID && !VME_RMW
    |=> !PCI_LOCK) else $error("lock without read-modify-write");
  chk_space_rsv: assert property (DEC_HIT |-> PCI_SPACE != 2'h3)
    else $error("reserved space claimed");
  // Main scenarios reached.
  cover property (DEC_HIT);
  cover property (POST_WRITE);
  cover property (PCI_LOCK);
endmodule : vsid_properties
